// ---- arcl_pkg.sv ----
// Functional notes
// R1 - status/control two bit 5 enables the automatic compare function.
// R2 - status/control two bit 4: 0 triggers below level, 1 at or above.
// R3 - result high holds upper two bits of 10-bit result; zero in 8-bit mode.
// R4 - result low holds lower eight bits, or the whole 8-bit result.
// R5 - both results update on completion unless compare enabled and not met.
// R6 - 10-bit: reading high blocks transfers until low is read; blocked results lost.
// R7 - 8-bit: no read interlock between high and low result registers.
// R8 - any resolution field change invalidates both result registers until next conversion; a transfer in the same cycle keeps them valid.
// R9 - configuration bit 7 selects high-speed (0) or low-power (1) profile.
// R10 - configuration bits 6:5 divide input clock by 1, 2, 4 or 8.
// R11 - configuration bit 4 selects short (0) or long (1) sample period.
// R12 - configuration bits 3:2: 00 8-bit, 10 10-bit; 01 and 11 reserved.
// R13 - configuration bits 1:0 select the input clock source for the divider.
package arcl_pkg;
    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_CFG = 8'h00;
    localparam logic [7:0] OFF_SC2 = 8'h04;
    localparam logic [7:0] OFF_RH = 8'h08;
    localparam logic [7:0] OFF_RL = 8'h0c;
    localparam logic [7:0] OFF_CMPH = 8'h10;
    localparam logic [7:0] OFF_CMPL = 8'h14;
    localparam logic [7:0] OFF_CTRL = 8'h18;
    localparam logic [7:0] OFF_IRQ_ST = 8'h1c;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h20;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CFG_LOW_POWER = 7;
    localparam int CFG_DIV_LSB = 5;
    localparam int CFG_LONG_SAMPLE = 4;
    localparam int CFG_MODE_LSB = 2;
    localparam int CFG_CLK_LSB = 0;
    localparam int SC2_ACTIVE = 7;
    localparam int SC2_CMP_EN = 5;
    localparam int SC2_CMP_GE = 4;
    localparam int SC2_VALID = 0;
    localparam int CTRL_START = 0;
    localparam int CTRL_CONTINUOUS = 1;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_LOST = 1;
    // ------------------------------------------------------------
    // reset values and encodings
    // ------------------------------------------------------------
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [7:0] SC2_RESET = 8'h00;
    localparam logic [9:0] CMP_RESET = 10'h000;
    localparam logic [1:0] IRQ_RESET = 2'h0;
    localparam logic [1:0] MODE_8BIT = 2'h0;
    localparam logic [1:0] MODE_10BIT = 2'h2;
    // ------------------------------------------------------------
    // timing counts, in conversion clock ticks
    // ------------------------------------------------------------
    localparam logic [3:0] SAMPLE_SHORT_TICKS = 4'h2;
    localparam logic [3:0] SAMPLE_LONG_TICKS = 4'hc;
    localparam logic [3:0] BITS_8 = 4'h8;
    localparam logic [3:0] BITS_10 = 4'ha;
    typedef enum logic [1:0] {
        CONV_IDLE = 2'b00,
        CONV_SAMPLE = 2'b01,
        CONV_BITS = 2'b11,
        CONV_DONE = 2'b10
    } arcl_state_e;
endpackage : arcl_pkg

// ---- arcl_conv_if.sv ----
`timescale 1ns/1ns
interface arcl_conv_if;
    logic start;
    logic tick;
    logic long_sample;
    logic mode10;
    logic busy;
    logic done;
    logic [9:0] result;
    modport ctl (output start, output tick, output long_sample, output mode10,
                 input busy, input done, input result);
    modport conv (input start, input tick, input long_sample, input mode10,
                  output busy, output done, output result);
endinterface : arcl_conv_if

// ---- arcl_clkdiv.sv ----
`timescale 1ns/1ns
module arcl_clkdiv (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // source and ratio
    input wire logic [2:0] alt_clk_en_i,
    input wire logic [1:0] src_sel_i,
    input wire logic [1:0] div_sel_i,
    // conversion clock enable
    output logic tick_o
);
    logic src_en;
    logic [2:0] cnt;
    logic [2:0] limit;

    // source 0 is the bus clock itself
    assign src_en = (src_sel_i == 2'h0) ? 1'b1 : alt_clk_en_i[src_sel_i - 2'h1]; // [R13]
    assign limit = 3'((4'h1 << div_sel_i) - 4'h1); // [R10]
    assign tick_o = src_en && (cnt >= limit);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt <= 3'h0;
        end else if (tick_o) begin
            cnt <= 3'h0;
        end else if (src_en) begin
            cnt <= cnt + 3'h1;
        end
    end

    property p_div_ratio;
        @(posedge clk_i) disable iff (rst_i)
        (tick_o && src_sel_i == 2'h0 && div_sel_i == 2'h3) |-> cnt == 3'h7;
    endproperty
    a_div_ratio: assert property (p_div_ratio) else $error("divide by 8 tick early"); // [R10]
endmodule : arcl_clkdiv

// ---- arcl_conv.sv ----
`timescale 1ns/1ns
module arcl_conv (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // input being converted
    input wire logic [9:0] sample_value_i,
    // control side
    arcl_conv_if.conv cif
);
    arcl_pkg::arcl_state_e state;
    logic [3:0] cnt;
    logic [9:0] held;

    assign cif.busy = (state != arcl_pkg::CONV_IDLE);
    assign cif.done = (state == arcl_pkg::CONV_DONE);

    // ------------------------------------------------------------
    // sequencer: sample period, then one tick per result bit
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= arcl_pkg::CONV_IDLE;
            cnt <= 4'h0;
        end else begin
            case (state)
                arcl_pkg::CONV_IDLE: begin
                    if (cif.start) begin
                        state <= arcl_pkg::CONV_SAMPLE;
                        cnt <= 4'h0;
                    end
                end
                arcl_pkg::CONV_SAMPLE: begin
                    if (cif.tick) begin
                        if (cnt == (cif.long_sample ? arcl_pkg::SAMPLE_LONG_TICKS
                                : arcl_pkg::SAMPLE_SHORT_TICKS) - 4'h1) begin // [R11]
                            state <= arcl_pkg::CONV_BITS;
                            cnt <= 4'h0;
                        end else begin
                            cnt <= cnt + 4'h1;
                        end
                    end
                end
                arcl_pkg::CONV_BITS: begin
                    if (cif.tick) begin
                        if (cnt == (cif.mode10 ? arcl_pkg::BITS_10 : arcl_pkg::BITS_8) - 4'h1) begin
                            state <= arcl_pkg::CONV_DONE;
                        end else begin
                            cnt <= cnt + 4'h1;
                        end
                    end
                end
                arcl_pkg::CONV_DONE: begin
                    state <= arcl_pkg::CONV_IDLE;
                end
                default: begin
                    state <= arcl_pkg::CONV_IDLE;
                end
            endcase
        end
    end

    // value is held at the end of the sample period
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            held <= 10'h000;
        end else if (state == arcl_pkg::CONV_SAMPLE && cif.tick) begin
            held <= sample_value_i;
        end
    end

    // 8-bit results keep the upper eight bits of the input
    assign cif.result = cif.mode10 ? held : {2'h0, held[9:2]}; // [R12]

    property p_done_one;
        @(posedge clk_i) disable iff (rst_i)
        cif.done |=> !cif.done;
    endproperty
    a_done_one: assert property (p_done_one) else $error("done lasted more than a cycle");
endmodule : arcl_conv

// ---- arcl_top.sv ----
`timescale 1ns/1ns
module arcl_top (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic [7:0] adr_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    input wire logic we_i,
    input wire logic [3:0] sel_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    output logic ack_o,
    // converter side
    input wire logic [9:0] sample_value_i,
    input wire logic [2:0] alt_clk_en_i,
    output logic low_power_o,
    output logic conversion_clock_o,
    // interrupt
    output logic irq_o
);
    arcl_conv_if cif ();

    logic [7:0] configuration_reg;
    logic compare_function_enable;
    logic compare_greater_equal_select;
    logic [9:0] compare_level;
    logic continuous;
    logic start_pulse;
    logic [1:0] result_bit_nine_eight;
    logic [7:0] result_low_reg;
    logic result_valid;
    logic locked;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic tick;
    logic taken;
    logic wr;
    logic rd;
    logic mode10;
    logic cmp_met;
    logic update;
    logic lost;
    logic [7:0] next_rdata;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    // a request is taken once; ack answers one cycle later
    assign taken = cyc_i && stb_i && !ack_o;
    assign wr = taken && we_i && sel_i[0];
    assign rd = taken && !we_i;
    // reserved code 11 behaves as 10-bit, 01 as 8-bit
    assign mode10 = configuration_reg[arcl_pkg::CFG_MODE_LSB + 1]; // [R12]

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= taken;
        end
    end

    // ------------------------------------------------------------
    // configuration and control registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            configuration_reg <= arcl_pkg::CFG_RESET;
        end else if (wr && adr_i == arcl_pkg::OFF_CFG) begin
            configuration_reg <= dat_i[7:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            compare_function_enable <= arcl_pkg::SC2_RESET[arcl_pkg::SC2_CMP_EN];
            compare_greater_equal_select <= arcl_pkg::SC2_RESET[arcl_pkg::SC2_CMP_GE];
        end else if (wr && adr_i == arcl_pkg::OFF_SC2) begin
            compare_function_enable <= dat_i[arcl_pkg::SC2_CMP_EN]; // [R1]
            compare_greater_equal_select <= dat_i[arcl_pkg::SC2_CMP_GE]; // [R2]
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            compare_level <= arcl_pkg::CMP_RESET;
        end else if (wr && adr_i == arcl_pkg::OFF_CMPH) begin
            compare_level[9:8] <= dat_i[1:0];
        end else if (wr && adr_i == arcl_pkg::OFF_CMPL) begin
            compare_level[7:0] <= dat_i[7:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            continuous <= 1'b0;
            start_pulse <= 1'b0;
        end else begin
            start_pulse <= wr && adr_i == arcl_pkg::OFF_CTRL && dat_i[arcl_pkg::CTRL_START];
            if (wr && adr_i == arcl_pkg::OFF_CTRL) begin
                continuous <= dat_i[arcl_pkg::CTRL_CONTINUOUS];
            end
        end
    end

    // ------------------------------------------------------------
    // conversion clock and sequencer
    // ------------------------------------------------------------
    arcl_clkdiv u_div (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .alt_clk_en_i(alt_clk_en_i),
        .src_sel_i(configuration_reg[arcl_pkg::CFG_CLK_LSB +: 2]), // [R13]
        .div_sel_i(configuration_reg[arcl_pkg::CFG_DIV_LSB +: 2]), // [R10]
        .tick_o(tick)
    );

    assign cif.tick = tick;
    assign cif.start = start_pulse || (continuous && !cif.busy);
    assign cif.long_sample = configuration_reg[arcl_pkg::CFG_LONG_SAMPLE]; // [R11]
    assign cif.mode10 = mode10;

    arcl_conv u_conv (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sample_value_i(sample_value_i),
        .cif(cif)
    );

    assign low_power_o = configuration_reg[arcl_pkg::CFG_LOW_POWER]; // [R9]
    assign conversion_clock_o = tick;

    // ------------------------------------------------------------
    // compare and result transfer
    // ------------------------------------------------------------
    // 8-bit mode compares against the low byte of the level only
    always_comb begin
        if (!compare_function_enable) begin
            cmp_met = 1'b1;
        end else if (compare_greater_equal_select) begin
            cmp_met = mode10 ? (cif.result >= compare_level)
                : (cif.result[7:0] >= compare_level[7:0]); // [R2]
        end else begin
            cmp_met = mode10 ? (cif.result < compare_level)
                : (cif.result[7:0] < compare_level[7:0]); // [R2]
        end
    end

    assign update = cif.done && cmp_met && !locked; // [R5]
    assign lost = cif.done && cmp_met && locked; // [R6]

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            result_bit_nine_eight <= 2'h0;
            result_low_reg <= 8'h00;
        end else if (update) begin
            result_bit_nine_eight <= mode10 ? cif.result[9:8] : 2'h0; // [R3]
            result_low_reg <= cif.result[7:0]; // [R4]
        end
    end

    // a resolution write that changes the field drops the results, except in a cycle where a transfer also lands
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            result_valid <= 1'b0;
        end else if (update) begin
            result_valid <= 1'b1;
        end else if (wr && adr_i == arcl_pkg::OFF_CFG
                && dat_i[arcl_pkg::CFG_MODE_LSB +: 2]
                   != configuration_reg[arcl_pkg::CFG_MODE_LSB +: 2]) begin
            result_valid <= 1'b0; // [R8]
        end
    end

    // read interlock exists in 10-bit mode only
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            locked <= 1'b0;
        end else if (!mode10) begin
            locked <= 1'b0; // [R7]
        end else if (rd && adr_i == arcl_pkg::OFF_RL) begin
            locked <= 1'b0; // [R6]
        end else if (rd && adr_i == arcl_pkg::OFF_RH) begin
            locked <= 1'b1; // [R6]
        end
    end

    // ------------------------------------------------------------
    // interrupt status, set wins over clear
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_status <= arcl_pkg::IRQ_RESET;
            irq_mask <= arcl_pkg::IRQ_RESET;
        end else begin
            irq_status[arcl_pkg::IRQ_DONE] <= update || (irq_status[arcl_pkg::IRQ_DONE]
                && !(wr && adr_i == arcl_pkg::OFF_IRQ_ST && dat_i[arcl_pkg::IRQ_DONE]));
            irq_status[arcl_pkg::IRQ_LOST] <= lost || (irq_status[arcl_pkg::IRQ_LOST]
                && !(wr && adr_i == arcl_pkg::OFF_IRQ_ST && dat_i[arcl_pkg::IRQ_LOST]));
            if (wr && adr_i == arcl_pkg::OFF_IRQ_MASK) begin
                irq_mask <= dat_i[1:0];
            end
        end
    end

    assign irq_o = |(irq_status & irq_mask);

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    always_comb begin
        next_rdata = 8'h00;
        case (adr_i)
            arcl_pkg::OFF_CFG: next_rdata = configuration_reg;
            arcl_pkg::OFF_SC2: begin
                next_rdata[arcl_pkg::SC2_ACTIVE] = cif.busy;
                next_rdata[arcl_pkg::SC2_CMP_EN] = compare_function_enable;
                next_rdata[arcl_pkg::SC2_CMP_GE] = compare_greater_equal_select;
                next_rdata[arcl_pkg::SC2_VALID] = result_valid;
            end
            arcl_pkg::OFF_RH: next_rdata = {6'h00, mode10 ? result_bit_nine_eight : 2'h0}; // [R3]
            arcl_pkg::OFF_RL: next_rdata = result_low_reg;
            arcl_pkg::OFF_CMPH: next_rdata = {6'h00, compare_level[9:8]};
            arcl_pkg::OFF_CMPL: next_rdata = compare_level[7:0];
            arcl_pkg::OFF_CTRL: next_rdata = {6'h00, continuous, 1'b0};
            arcl_pkg::OFF_IRQ_ST: next_rdata = {6'h00, irq_status};
            arcl_pkg::OFF_IRQ_MASK: next_rdata = {6'h00, irq_mask};
            default: next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0000_0000;
        end else if (rd) begin
            dat_o <= {24'h00_0000, next_rdata};
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_cmp_hold;
        @(posedge clk_i) disable iff (rst_i)
        (cif.done && compare_function_enable && !cmp_met)
            |=> $stable(result_low_reg) && $stable(result_bit_nine_eight);
    endproperty
    a_cmp_hold: assert property (p_cmp_hold) else $error("result changed on failed compare"); // [R1]

    property p_cmp_ge;
        @(posedge clk_i) disable iff (rst_i)
        (cif.done && !locked && mode10 && compare_function_enable
            && compare_greater_equal_select && cif.result >= compare_level)
            |=> result_low_reg == $past(cif.result[7:0]);
    endproperty
    a_cmp_ge: assert property (p_cmp_ge) else $error("greater-equal compare did not load"); // [R2]

    property p_high_zero;
        @(posedge clk_i) disable iff (rst_i)
        (rd && !mode10 && adr_i == arcl_pkg::OFF_RH) |=> dat_o[1:0] == 2'h0;
    endproperty
    a_high_zero: assert property (p_high_zero) else $error("high bits set in 8-bit mode"); // [R3]

    property p_low_load;
        @(posedge clk_i) disable iff (rst_i)
        (cif.done && !compare_function_enable && !locked)
            |=> result_low_reg == $past(cif.result[7:0]) && result_valid;
    endproperty
    a_low_load: assert property (p_low_load) else $error("low result not loaded"); // [R4]

    property p_update;
        @(posedge clk_i) disable iff (rst_i)
        update |=> irq_status[arcl_pkg::IRQ_DONE];
    endproperty
    a_update: assert property (p_update) else $error("completion flag not set"); // [R5]

    property p_lock;
        @(posedge clk_i) disable iff (rst_i)
        (cif.done && cmp_met && locked)
            |=> $stable(result_low_reg) && irq_status[arcl_pkg::IRQ_LOST];
    endproperty
    a_lock: assert property (p_lock) else $error("blocked result was transferred"); // [R6]

    property p_no_lock8;
        @(posedge clk_i) disable iff (rst_i)
        !mode10 |=> !locked || mode10;
    endproperty
    a_no_lock8: assert property (p_no_lock8) else $error("interlock active in 8-bit mode"); // [R7]

    property p_mode_inval;
        @(posedge clk_i) disable iff (rst_i)
        (!$past(update) && $changed(configuration_reg[arcl_pkg::CFG_MODE_LSB +: 2]))
            |-> !result_valid;
    endproperty
    a_mode_inval: assert property (p_mode_inval) else $error("results valid after mode change"); // [R8]

    // ------------------------------------------------------------
    // lock, flag, start and conversion clock checks
    // ------------------------------------------------------------
    property p_lock_set;
        @(posedge clk_i) disable iff (rst_i)
        (rd && mode10 && adr_i == arcl_pkg::OFF_RH) |=> locked;
    endproperty
    a_lock_set: assert property (p_lock_set) else $error("high read did not lock"); // [R6]

    property p_lock_clr;
        @(posedge clk_i) disable iff (rst_i)
        (rd && adr_i == arcl_pkg::OFF_RL) |=> !locked;
    endproperty
    a_lock_clr: assert property (p_lock_clr) else $error("low read did not unlock"); // [R6]

    property p_valid_set;
        @(posedge clk_i) disable iff (rst_i)
        update |=> result_valid;
    endproperty
    a_valid_set: assert property (p_valid_set) else $error("result not marked valid"); // [R5]

    property p_start;
        @(posedge clk_i) disable iff (rst_i)
        (cif.start && !cif.busy) |=> cif.busy;
    endproperty
    a_start: assert property (p_start) else $error("start ignored while idle");

    property p_irq_clr;
        @(posedge clk_i) disable iff (rst_i)
        (wr && !update && adr_i == arcl_pkg::OFF_IRQ_ST && dat_i[arcl_pkg::IRQ_DONE])
            |=> !irq_status[arcl_pkg::IRQ_DONE];
    endproperty
    a_irq_clr: assert property (p_irq_clr) else $error("completion flag not cleared");

    property p_div2;
        @(posedge clk_i) disable iff (rst_i)
        (tick && !wr && configuration_reg[arcl_pkg::CFG_DIV_LSB +: 2] == 2'h1) |=> !tick;
    endproperty
    a_div2: assert property (p_div2) else $error("divide by 2 ticked twice"); // [R10]

    property p_src_off;
        @(posedge clk_i) disable iff (rst_i)
        (configuration_reg[arcl_pkg::CFG_CLK_LSB +: 2] == 2'h1 && !alt_clk_en_i[0]) |-> !tick;
    endproperty
    a_src_off: assert property (p_src_off) else $error("tick from a stopped source"); // [R13]
endmodule : arcl_top

// ---- tb.sv ----
`timescale 1ns/1ns
module tb;
    // ----------------------------------------
    // stimulus and observation
    // ----------------------------------------
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] adr_i = 8'h00;
    logic [31:0] dat_i = 32'h0;
    logic [31:0] dat_o;
    logic we_i = 1'b0;
    logic [3:0] sel_i = 4'h0;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic ack_o;
    logic [9:0] sample_value_i = 10'h000;
    logic [2:0] alt_clk_en_i = 3'h0;
    logic low_power_o;
    logic conversion_clock_o;
    logic irq_o;
    int num_errors = 0;
    int samples_checked = 0;
    int lat;
    int ts;
    int tl;
    logic [31:0] rd;

    always #25 clk_i = ~clk_i;

    arcl_top arcl_top_inst (
        .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o),
        .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
        .sample_value_i(sample_value_i), .alt_clk_en_i(alt_clk_en_i),
        .low_power_o(low_power_o), .conversion_clock_o(conversion_clock_o), .irq_o(irq_o)
    );

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // one classic cycle; read data lands in rd, cycles to ack in lat
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        sel_i <= 4'h1;
        dat_i <= {24'h0, d};
        lat = 0;
        do begin
            @(posedge clk_i);
            lat++;
        end while (ack_o !== 1'b1);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
    endtask : wb

    // start, wait for the completion interrupt, clear it; t is the cycle count
    task automatic conv(output int t);
        wb(1'b1, arcl_pkg::OFF_CTRL, 8'h01);
        t = 0;
        while (irq_o !== 1'b1 && t < 500) begin
            @(posedge clk_i);
            t++;
        end
        chk("irq_set", irq_o, 32'h1);
        wb(1'b1, arcl_pkg::OFF_IRQ_ST, 8'h03);
        chk("irq_clr", irq_o, 32'h0);
    endtask : conv

    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 8'h00);
        chk(nm, rd, exp);
    endtask : rd_chk

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset;
        rd_chk("cfg_rst", arcl_pkg::OFF_CFG, 32'h0);
        chk("ack_lat", lat, 32'd2);
        rd_chk("sc2_rst", arcl_pkg::OFF_SC2, 32'h0);
        rd_chk("unmapped", 8'hfc, 32'h0);
        chk("irq_rst", irq_o, 32'h0);
    endtask : t_reset

    task automatic t_cfg;
        wb(1'b1, arcl_pkg::OFF_CFG, 8'h80);
        chk("low_power", low_power_o, 32'h1);
        rd_chk("cfg_rb", arcl_pkg::OFF_CFG, 32'h80);
        wb(1'b1, arcl_pkg::OFF_CFG, 8'h00);
        chk("high_speed", low_power_o, 32'h0);
    endtask : t_cfg

    // tick counts over 32 cycles; window is a multiple of every period
    task automatic count_ticks(input logic [7:0] cfg, input int exp);
        int n;
        wb(1'b1, arcl_pkg::OFF_CFG, cfg);
        repeat (8) @(posedge clk_i);
        n = 0;
        repeat (32) begin
            @(posedge clk_i);
            if (conversion_clock_o === 1'b1) n++;
        end
        chk("ticks", n, exp);
    endtask : count_ticks

    task automatic t_div;
        alt_clk_en_i <= 3'b100;
        for (int c = 0; c < 4; c++) count_ticks(8'(c << 5), 32 >> c);
        count_ticks(8'h03, 32);
        count_ticks(8'h01, 0);
        wb(1'b1, arcl_pkg::OFF_CFG, 8'h00);
    endtask : t_div

    task automatic t_conv8;
        sample_value_i <= 10'h2a5;
        wb(1'b1, arcl_pkg::OFF_IRQ_MASK, 8'h00);
        wb(1'b1, arcl_pkg::OFF_CTRL, 8'h01);
        repeat (60) @(posedge clk_i);
        chk("irq_masked", irq_o, 32'h0);
        wb(1'b1, arcl_pkg::OFF_IRQ_MASK, 8'h01);
        chk("irq_unmasked", irq_o, 32'h1);
        wb(1'b1, arcl_pkg::OFF_IRQ_ST, 8'h03);
        rd_chk("rh8", arcl_pkg::OFF_RH, 32'h00);
        rd_chk("rl8", arcl_pkg::OFF_RL, 32'ha9);
        wb(1'b0, arcl_pkg::OFF_RH, 8'h00);
        sample_value_i <= 10'h155;
        conv(ts);
        rd_chk("rl8_nolock", arcl_pkg::OFF_RL, 32'h55);
    endtask : t_conv8

    task automatic t_conv10;
        sample_value_i <= 10'h2a5;
        wb(1'b1, arcl_pkg::OFF_CFG, 8'h08);
        conv(ts);
        rd_chk("rh10", arcl_pkg::OFF_RH, 32'h02);
        rd_chk("rl10", arcl_pkg::OFF_RL, 32'ha5);
        rd_chk("valid", arcl_pkg::OFF_SC2, 32'h01);
        wb(1'b1, arcl_pkg::OFF_CFG, 8'h18);
        conv(tl);
        chk("long_sample", tl - ts, 32'd10);
        wb(1'b1, arcl_pkg::OFF_CFG, 8'h00);
        rd_chk("invalid", arcl_pkg::OFF_SC2, 32'h00);
        rd_chk("rh_8mode", arcl_pkg::OFF_RH, 32'h00);
        wb(1'b1, arcl_pkg::OFF_CFG, 8'h08);
    endtask : t_conv10

    task automatic t_lock;
        conv(ts);
        wb(1'b0, arcl_pkg::OFF_RH, 8'h00);
        sample_value_i <= 10'h0f0;
        wb(1'b1, arcl_pkg::OFF_CTRL, 8'h01);
        repeat (60) @(posedge clk_i);
        wb(1'b0, arcl_pkg::OFF_IRQ_ST, 8'h00);
        chk("lost", rd & 32'h2, 32'h2);
        rd_chk("rl_kept", arcl_pkg::OFF_RL, 32'ha5);
        wb(1'b1, arcl_pkg::OFF_IRQ_ST, 8'h03);
        conv(ts);
        rd_chk("rh_new", arcl_pkg::OFF_RH, 32'h00);
        rd_chk("rl_new", arcl_pkg::OFF_RL, 32'hf0);
    endtask : t_lock

    task automatic t_cmp;
        wb(1'b1, arcl_pkg::OFF_CMPH, 8'h03);
        wb(1'b1, arcl_pkg::OFF_CMPL, 8'h00);
        wb(1'b1, arcl_pkg::OFF_SC2, 8'h30);
        sample_value_i <= 10'h1ff;
        wb(1'b1, arcl_pkg::OFF_CTRL, 8'h01);
        repeat (60) @(posedge clk_i);
        wb(1'b1, arcl_pkg::OFF_IRQ_ST, 8'h03);
        rd_chk("cmp_miss", arcl_pkg::OFF_RL, 32'hf0);
        wb(1'b1, arcl_pkg::OFF_SC2, 8'h20);
        conv(ts);
        rd_chk("cmp_hit_h", arcl_pkg::OFF_RH, 32'h01);
        rd_chk("cmp_hit_l", arcl_pkg::OFF_RL, 32'hff);
        sample_value_i <= 10'h300;
        wb(1'b1, arcl_pkg::OFF_SC2, 8'h30);
        conv(ts);
        rd_chk("cmp_ge_h", arcl_pkg::OFF_RH, 32'h03);
        rd_chk("cmp_ge_l", arcl_pkg::OFF_RL, 32'h00);
        wb(1'b1, arcl_pkg::OFF_CTRL, 8'h02);
        rd_chk("ctrl", arcl_pkg::OFF_CTRL, 32'h02);
        wb(1'b1, arcl_pkg::OFF_IRQ_ST, 8'h03);
        repeat (40) @(posedge clk_i);
        chk("continuous", irq_o, 32'h1);
        wb(1'b1, arcl_pkg::OFF_CTRL, 8'h00);
    endtask : t_cmp

    // ----------------------------------------
    // run control
    // ----------------------------------------
    task automatic close_out;
        $display("checked %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : close_out

    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_cfg();
        t_div();
        t_conv8();
        t_conv10();
        t_lock();
        t_cmp();
        close_out();
    end

    // whole run needs under a thousand cycles
    initial begin
        #2000000;
        num_errors++;
        close_out();
    end
endmodule : tb
